// ==== verilog/capture_timer.sv ====
// Eight-bit up-counting capture timer with Avalon-MM register slave.
// Assumes pin and power-mode inputs synchronous to clk_in.
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "capture_timer_params.svh"

module capture_timer #(
   parameter int WATCH_DIV = `CT_DIV_WATCH
) (
   // Clock and reset
   input  wire logic                         clk_in,
   input  wire logic                         sys_rst_in,
   // Avalon-MM slave
   input  wire logic [7:0]                   avs_address_in,
   input  wire logic                         avs_read_in,
   input  wire logic                         avs_write_in,
   input  wire logic [31:0]                  avs_writedata_in,
   input  wire logic [3:0]                   avs_byteenable_in,
   output logic [31:0]                       avs_readdata_out,
   output logic                              avs_waitrequest_out,
   // Pin and system
   input  wire logic                         capture_input_port_pin_in,
   input  wire capture_timer_pkg::power_mode_t power_mode_in,
   // Status
   output logic                              capture_timer_request_flag_out,
   output logic                              irq_out
);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   capture_timer_pkg::mode_t mode_q;
   logic [7:0] capture_counter_q;
   logic [7:0] rising_capture_reg_q;
   logic [7:0] falling_capture_reg_q;
   logic       capture_pin_function_bit_q;
   logic       noise_cancel_select_q;
   logic [1:0] subclock_sel_q;
   logic       capture_timer_request_flag_q;
   logic       capture_timer_irq_enable_q;
   logic       ack_q;
   logic [31:0] rdata_q;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic       acc;
   logic       wr;
   logic       wr_lo;

   assign acc   = (avs_read_in | avs_write_in) & ~ack_q;
   assign wr    = avs_write_in & ack_q;
   assign wr_lo = wr & avs_byteenable_in[0];
   // One wait cycle, answer on second edge
   assign avs_waitrequest_out = ~ack_q;
   assign avs_readdata_out    = rdata_q;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc;
      end
   end

   // ------------------------------------------------------------
   // Power mode gating
   // ------------------------------------------------------------
   logic run_en;
   logic mode_wr_ok;

   always_comb begin
      case (power_mode_in)
         capture_timer_pkg::PM_STANDBY,
         capture_timer_pkg::PM_MODSTBY: run_en = 1'b0;
         // sub modes need watch quarter clock
         capture_timer_pkg::PM_WATCH,
         capture_timer_pkg::PM_SUBACT,
         capture_timer_pkg::PM_SUBSLEEP:
            run_en = (mode_q.clock_select == capture_timer_pkg::CK_WQ) &&
                     (subclock_sel_q == `CT_SUBCK_HALF);
         default: run_en = 1'b1;
      endcase
   end

   // mode writes only active or subactive
   assign mode_wr_ok = (power_mode_in == capture_timer_pkg::PM_ACTIVE) ||
                       (power_mode_in == capture_timer_pkg::PM_SUBACT);

   // ------------------------------------------------------------
   // Clock dividers
   // ------------------------------------------------------------
   logic [`CT_DIV_SYS-1:0] sys_div_q;
   logic [7:0]             watch_div_q;
   logic                   sel_clk;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         sys_div_q   <= '0;
         watch_div_q <= '0;
      end else begin
         sys_div_q   <= sys_div_q + 1'b1;
         watch_div_q <= watch_div_q + 8'h01;
      end
   end

   function automatic logic pick_clk(input capture_timer_pkg::clock_sel_t s,
                                     input logic [`CT_DIV_SYS-1:0] d,
                                     input logic [7:0] w);
      case (s)
         capture_timer_pkg::CK_DIV64: pick_clk = d[5];
         capture_timer_pkg::CK_DIV32: pick_clk = d[4];
         capture_timer_pkg::CK_DIV2:  pick_clk = d[0];
         // Quarter watch rate: two taps above the watch clock
         default:                     pick_clk = w[WATCH_DIV+1];
      endcase
   endfunction : pick_clk

   assign sel_clk = pick_clk(mode_q.clock_select, sys_div_q, watch_div_q);

   // falling edge of selected clock; switch also seen here
   logic sel_clk_q;
   logic tick;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         sel_clk_q <= 1'b0;
      end else begin
         sel_clk_q <= sel_clk;
      end
   end

   assign tick = sel_clk_q & ~sel_clk & run_en;

   // ------------------------------------------------------------
   // Capture input path
   // ------------------------------------------------------------
   logic filt_out;
   logic raw_in;
   logic cap_sig;
   logic cap_sig_q;
   capture_timer_pkg::edge_evt_t evt;

   capture_noise_filter #(
      .STAGES (`CT_NC_STAGES)
   ) u_filter (
      .clk_in       (clk_in),
      .sys_rst_in   (sys_rst_in),
      // Canceler off: chain fills with ones, so enabling it starts high
      .sample_en_in (tick | ~noise_cancel_select_q),
      .din_in       (capture_input_port_pin_in | ~noise_cancel_select_q),
      .dout_out     (filt_out)
   );

   // filtered level follows canceler state; select swaps source
   assign raw_in  = noise_cancel_select_q ? filt_out : capture_input_port_pin_in;
   // pin function off forces low; toggling it with the input high makes edges
   assign cap_sig = capture_pin_function_bit_q & raw_in & run_en | 
                    capture_pin_function_bit_q & raw_in & ~run_en & cap_sig_q;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cap_sig_q <= 1'b0;
      end else begin
         cap_sig_q <= cap_sig;
      end
   end

   assign evt.rise = cap_sig & ~cap_sig_q;
   assign evt.fall = ~cap_sig & cap_sig_q;

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   logic clr_evt;
   logic ovf;

   // clear on same edge that captures
   assign clr_evt = (mode_q.counter_clear_select[1] & evt.rise) |
                    (mode_q.counter_clear_select[0] & evt.fall);
   assign ovf     = tick & (capture_counter_q == 8'hff);

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         capture_counter_q <= `CT_RST_BYTE;
      end else if (wr_lo && avs_address_in == `CT_OFS_COUNT) begin
         capture_counter_q <= avs_writedata_in[7:0];
      end else if (clr_evt && capture_pin_function_bit_q) begin
         capture_counter_q <= `CT_RST_BYTE;
      end else if (tick) begin
         capture_counter_q <= capture_counter_q + 8'h01;
      end
   end

   // capture on edges, counter value before clear
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rising_capture_reg_q  <= `CT_RST_BYTE;
         falling_capture_reg_q <= `CT_RST_BYTE;
      end else if (run_en) begin
         if (evt.rise) begin
            rising_capture_reg_q <= capture_counter_q;
         end
         if (evt.fall) begin
            falling_capture_reg_q <= capture_counter_q;
         end
      end
   end

   // ------------------------------------------------------------
   // Mode and port control
   // ------------------------------------------------------------
   logic ovfh_set;
   logic ovfl_set;

   assign ovfh_set = ovf & capture_pin_function_bit_q & cap_sig;
   assign ovfl_set = ovf & ~(capture_pin_function_bit_q & cap_sig);

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         mode_q <= capture_timer_pkg::mode_t'(`CT_RST_BYTE);
      end else begin
         if (wr_lo && mode_wr_ok && avs_address_in == `CT_OFS_MODE) begin
            mode_q.clock_select <= capture_timer_pkg::clock_sel_t'(
               avs_writedata_in[`CT_MODE_CKS_HI:`CT_MODE_CKS_LO]);
            mode_q.counter_clear_select <=
               avs_writedata_in[`CT_MODE_CCLR_HI:`CT_MODE_CCLR_LO];
            mode_q.interrupt_edge_select <= avs_writedata_in[`CT_MODE_INTERRUPT_EDGE_SELECT];
            mode_q.ovie <= avs_writedata_in[`CT_MODE_OVIE];
            // Software clears overflow by writing zero; set wins
            mode_q.ovfl <= ovfl_set | (mode_q.ovfl & avs_writedata_in[`CT_MODE_OVFL]);
            mode_q.ovfh <= ovfh_set | (mode_q.ovfh & avs_writedata_in[`CT_MODE_OVFH]);
         end else begin
            mode_q.ovfl <= mode_q.ovfl | ovfl_set;
            mode_q.ovfh <= mode_q.ovfh | ovfh_set;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         capture_pin_function_bit_q <= 1'b0;
         noise_cancel_select_q      <= 1'b0;
         subclock_sel_q             <= `CT_RST_SUBCK;
      end else if (wr_lo && avs_address_in == `CT_OFS_PORT) begin
         capture_pin_function_bit_q <= avs_writedata_in[`CT_PORT_PINFN];
         noise_cancel_select_q      <= avs_writedata_in[`CT_PORT_NCS];
         subclock_sel_q <= avs_writedata_in[`CT_PORT_SUBCK+1:`CT_PORT_SUBCK];
      end
   end

   // ------------------------------------------------------------
   // Request flag
   // ------------------------------------------------------------
   logic req_set;
   logic edge_hit;

   // any detected edge matching select sets flag
   assign edge_hit = mode_q.interrupt_edge_select ? evt.rise : evt.fall;
   assign req_set  = (capture_pin_function_bit_q & edge_hit) |
                     (~capture_pin_function_bit_q & evt.fall & ~mode_q.interrupt_edge_select) |
                     ((ovfh_set | ovfl_set) & mode_q.ovie);

   // software clears flag by writing zero; set wins
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         capture_timer_request_flag_q <= 1'b0;
         capture_timer_irq_enable_q   <= 1'b0;
      end else if (wr_lo && avs_address_in == `CT_OFS_STATUS) begin
         capture_timer_request_flag_q <= req_set |
            (capture_timer_request_flag_q & avs_writedata_in[`CT_STAT_REQ]);
         capture_timer_irq_enable_q <= avs_writedata_in[`CT_STAT_IRQEN];
      end else begin
         capture_timer_request_flag_q <= capture_timer_request_flag_q | req_set;
      end
   end

   assign capture_timer_request_flag_out = capture_timer_request_flag_q;
   assign irq_out = capture_timer_request_flag_q & capture_timer_irq_enable_q;

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rdata_q <= '0;
      end else if (avs_read_in && !ack_q) begin
         case (avs_address_in)
            `CT_OFS_MODE:   rdata_q <= {24'h000000, mode_q};
            `CT_OFS_COUNT:  rdata_q <= {24'h000000, capture_counter_q};
            `CT_OFS_RISE:   rdata_q <= {24'h000000, rising_capture_reg_q};
            `CT_OFS_FALL:   rdata_q <= {24'h000000, falling_capture_reg_q};
            `CT_OFS_PORT:   rdata_q <= {28'h0000000, subclock_sel_q,
                                        noise_cancel_select_q,
                                        capture_pin_function_bit_q};
            `CT_OFS_STATUS: rdata_q <= {29'h00000000, cap_sig_q,
                                        capture_timer_irq_enable_q,
                                        capture_timer_request_flag_q};
            default:        rdata_q <= '0;
         endcase
      end
   end

endmodule : capture_timer

// ==== verilog/capture_timer_params.svh ====
// Constants for the edge capture timer: offsets, fields, resets, timing.
// Assumes inclusion by bare name from verilog/ sources.
`ifndef CAPTURE_TIMER_PARAMS_SVH
`define CAPTURE_TIMER_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define CT_OFS_MODE     8'h00
`define CT_OFS_COUNT    8'h04
`define CT_OFS_RISE     8'h08
`define CT_OFS_FALL     8'h0c
`define CT_OFS_PORT     8'h10
`define CT_OFS_STATUS   8'h14

// ------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------
`define CT_MODE_CKS_LO  0
`define CT_MODE_CKS_HI  1
`define CT_MODE_CCLR_LO 2
`define CT_MODE_CCLR_HI 3
`define CT_MODE_INTERRUPT_EDGE_SELECT   4
`define CT_MODE_OVIE    5
`define CT_MODE_OVFL    6
`define CT_MODE_OVFH    7

// ------------------------------------------------------------
// Port control and status fields
// ------------------------------------------------------------
`define CT_PORT_PINFN   0
`define CT_PORT_NCS     1
`define CT_PORT_SUBCK   2
`define CT_STAT_REQ     0
`define CT_STAT_IRQEN   1
`define CT_STAT_SYNC    2

// ------------------------------------------------------------
// Reset values and divider figures
// ------------------------------------------------------------
`define CT_RST_BYTE     8'h00
`define CT_RST_SUBCK    2'h0
`define CT_NC_STAGES    5
`define CT_DIV_SYS      6
`define CT_DIV_WATCH    4
`define CT_SUBCK_HALF   2'h1

`endif

// ==== verilog/capture_timer_pkg.sv ====
// Types shared by the edge capture timer.
// Assumes capture_timer_params.svh is compiled alongside.
package capture_timer_pkg;

   typedef enum logic [2:0] {
      PM_ACTIVE   = 3'b000,
      PM_SLEEP    = 3'b001,
      PM_WATCH    = 3'b010,
      PM_SUBACT   = 3'b011,
      PM_SUBSLEEP = 3'b100,
      PM_STANDBY  = 3'b101,
      PM_MODSTBY  = 3'b110
   } power_mode_t;

   typedef enum logic [1:0] {
      CK_DIV64 = 2'b00,
      CK_DIV32 = 2'b01,
      CK_DIV2  = 2'b10,
      CK_WQ    = 2'b11
   } clock_sel_t;

   typedef struct packed {
      logic rise;
      logic fall;
   } edge_evt_t;

   typedef struct packed {
      logic       ovfh;
      logic       ovfl;
      logic       ovie;
      logic       interrupt_edge_select;
      logic [1:0] counter_clear_select;
      clock_sel_t clock_select;
   } mode_t;

endpackage : capture_timer_pkg

// ==== verilog/capture_noise_filter.sv ====
// Five-stage majority-free noise canceler for the capture input.
// Assumes one clock; sample_en_in is a one-cycle sampling strobe.
`timescale 1ns/1ps
`include "capture_timer_params.svh"

module capture_noise_filter #(
   parameter int STAGES = `CT_NC_STAGES
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic sys_rst_in,
   // Sampling
   input  wire logic sample_en_in,
   input  wire logic din_in,
   // Filtered level
   output logic      dout_out
);

   logic [STAGES-1:0] shift_q;
   logic              out_q;

   // Shift chain of latches
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         shift_q <= '0;
      end else if (sample_en_in) begin
         shift_q <= {shift_q[STAGES-2:0], din_in};
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         out_q <= 1'b0;
      end else if (&shift_q) begin
         out_q <= 1'b1;
      end else if (~|shift_q) begin
         out_q <= 1'b0;
      end
   end

   assign dout_out = out_q;

endmodule : capture_noise_filter

// ==== sim/capture_timer_monitor.sv ====
// Port-level checker for the capture timer.
// Assumes binding onto capture_timer; sees its ports only.
`timescale 1ns/1ps
module capture_timer_monitor #(
   parameter int WATCH_DIV = 4
) (
   // Clock and reset
   input  wire logic                           clk_in,
   input  wire logic                           sys_rst_in,
   // Avalon-MM slave
   input  wire logic [7:0]                     avs_address_in,
   input  wire logic                           avs_read_in,
   input  wire logic                           avs_write_in,
   input  wire logic [31:0]                    avs_writedata_in,
   input  wire logic [3:0]                     avs_byteenable_in,
   input  wire logic [31:0]                    avs_readdata_out,
   input  wire logic                           avs_waitrequest_out,
   // Pin and system
   input  wire logic                           capture_input_port_pin_in,
   input  wire capture_timer_pkg::power_mode_t power_mode_in,
   // Status
   input  wire logic                           capture_timer_request_flag_out,
   input  wire logic                           irq_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   // ------------------------------------------------------------
   // Handshake
   // ------------------------------------------------------------
   sequence s_req_wait;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence s_answer;
      !avs_waitrequest_out;
   endsequence
   property p_wait_low;
      s_req_wait |=> s_answer;
   endproperty
   a_wait_low: assert property (p_wait_low) else $error("no answer after request");
   property p_wait_pulse;
      s_answer |=> avs_waitrequest_out;
   endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("answer longer than one cycle");
   property p_wait_cause;
      s_answer |-> $past(avs_read_in || avs_write_in);
   endproperty
   a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
   property p_rdata_hold;
      !(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved between reads");
   property p_upper_zero;
      s_answer |-> avs_readdata_out[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

   // ------------------------------------------------------------
   // Flag and reset
   // ------------------------------------------------------------
   property p_irq_flag;
      irq_out |-> capture_timer_request_flag_out;
   endproperty
   a_irq_flag: assert property (p_irq_flag) else $error("interrupt without flag");
   // Only a register write may clear the sticky flag
   property p_flag_sticky;
      capture_timer_request_flag_out && !avs_write_in |=> capture_timer_request_flag_out;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without write");
   property p_rst_state;
      disable iff (1'b0) sys_rst_in |=> avs_waitrequest_out && !irq_out
         && !capture_timer_request_flag_out && avs_readdata_out == 32'h00000000;
   endproperty
   a_rst_state: assert property (p_rst_state) else $error("outputs not cleared by reset");
endmodule : capture_timer_monitor

// ==== sim/pulse_source.sv ====
// External pulse source on the capture input pin.
// Assumes commands from the bench, changed just after rising edges.
`timescale 1ns/1ps
module pulse_source (
   // Clock
   input  wire logic       clk_in,
   // Commands
   input  wire logic       go_in,
   input  wire logic [7:0] width_in,
   input  wire logic       idle_level_in,
   // Pin
   output logic            pin_out
);
   logic [7:0] left_q = 8'h00;

   // Width counted in clocks; no reset so the pin never floats
   always_ff @(posedge clk_in) begin
      if (go_in) begin
         left_q <= width_in;
      end else if (left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
      end
   end
   assign pin_out = (left_q != 8'h00) ? !idle_level_in : idle_level_in;
endmodule : pulse_source

// ==== sim/test_capture_timer.sv ====
// Self-checking bench for the capture timer over Avalon-MM.
// Assumes capture_timer_params.svh and the package are compiled first.
`timescale 1ns/1ps
`include "capture_timer_params.svh"
module test_capture_timer;
   logic                           clk_in;
   logic                           sys_rst_in;
   logic [7:0]                     avs_address_in;
   logic                           avs_read_in;
   logic                           avs_write_in;
   logic [31:0]                    avs_writedata_in;
   logic [3:0]                     avs_byteenable_in;
   logic [31:0]                    avs_readdata_out;
   logic                           avs_waitrequest_out;
   logic                           pin;
   capture_timer_pkg::power_mode_t power_mode_in;
   logic                           capture_timer_request_flag_out;
   logic                           irq_out;
   logic                           go;
   logic [7:0]                     width;
   logic                           idle_level;
   int                             n_errors;
   int                             num_checks;
   logic [31:0]                    q;
   logic [31:0]                    c0;
   logic [31:0]                    c1;
   logic [7:0]                     offs [5];

   capture_timer dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .capture_input_port_pin_in(pin),
      .power_mode_in(power_mode_in), .irq_out(irq_out),
      .capture_timer_request_flag_out(capture_timer_request_flag_out));
   pulse_source src (.clk_in(clk_in), .go_in(go), .width_in(width),
      .idle_level_in(idle_level), .pin_out(pin));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   // Request held until waitrequest is sampled low at a rising edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_in);
      avs_address_in   <= a;
      avs_writedata_in <= d;
      avs_write_in     <= wr;
      avs_read_in      <= !wr;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_in);
         if (avs_waitrequest_out === 1'b0) break;
      end
      check("answer", 32'h0, {31'h0, n == 40});
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in  <= 1'b0;
   endtask : xfer
   task automatic chk_rd(input string name, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(name, exp, q & m);
   endtask : chk_rd
   task automatic pulse(input logic [7:0] w);
      @(posedge clk_in);
      width <= w;
      go    <= 1'b1;
      @(posedge clk_in);
      go    <= 1'b0;
   endtask : pulse
   // Count advance across a fixed gap, judged against a window
   task automatic span(input int gap, input int lo, input int hi);
      xfer(1'b0, `CT_OFS_COUNT, 32'h0);
      c0 = q;
      repeat (gap) @(posedge clk_in);
      xfer(1'b0, `CT_OFS_COUNT, 32'h0);
      c1 = (q - c0) & 32'hff;
      check("count advance", 32'h1, {31'h0, c1 >= lo && c1 <= hi});
   endtask : span

   // ------------------------------------------------------------
   // Clock, reset, watchdog
   // ------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = !clk_in;
   end
   initial begin
      repeat (30000) @(posedge clk_in);
      n_errors++;
      $display("CHECK FAILED run time expected end seen timeout");
      close_out();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      {avs_address_in, avs_read_in, avs_write_in, avs_writedata_in} = '0;
      avs_byteenable_in = 4'hf;
      power_mode_in = capture_timer_pkg::PM_ACTIVE;
      {go, width, idle_level, n_errors, num_checks} = '0;
      offs = '{`CT_OFS_MODE, `CT_OFS_RISE, `CT_OFS_FALL, `CT_OFS_PORT, `CT_OFS_STATUS};
      sys_rst_in = 1'b1;
      repeat (16) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      foreach (offs[i]) chk_rd("reset value", offs[i], 32'hffffffff, 32'h0);
      xfer(1'b1, 8'h20, 32'hff);
      chk_rd("unmapped", 8'h20, 32'hffffffff, 32'h0);
      xfer(1'b1, `CT_OFS_MODE, 32'h1e);
      chk_rd("mode", `CT_OFS_MODE, 32'h3f, 32'h1e);
      power_mode_in <= capture_timer_pkg::PM_SUBACT;
      xfer(1'b1, `CT_OFS_MODE, 32'h12);
      chk_rd("mode subactive", `CT_OFS_MODE, 32'h3f, 32'h12);
      for (int m = 1; m < 7; m++) begin
         if (m == 3) continue;
         power_mode_in <= capture_timer_pkg::power_mode_t'(m);
         xfer(1'b1, `CT_OFS_MODE, 32'h01);
         chk_rd("mode kept", `CT_OFS_MODE, 32'h3f, 32'h12);
      end
      power_mode_in <= capture_timer_pkg::PM_SUBACT;
      span(100, 0, 0);
      xfer(1'b1, `CT_OFS_PORT, 32'h04);
      xfer(1'b1, `CT_OFS_MODE, 32'h13);
      span(300, 3, 6);
      power_mode_in <= capture_timer_pkg::PM_STANDBY;
      span(100, 0, 0);
      power_mode_in <= capture_timer_pkg::PM_ACTIVE;
      xfer(1'b1, `CT_OFS_MODE, 32'h02);
      span(40, 20, 23);
      // Interval mode wraps past ff
      xfer(1'b1, `CT_OFS_COUNT, 32'hf0);
      repeat (60) @(posedge clk_in);
      chk_rd("overflow low", `CT_OFS_MODE, 32'h40, 32'h40);
      xfer(1'b1, `CT_OFS_MODE, 32'h12);
      // Switching edges with the pin held high
      idle_level <= 1'b1;
      xfer(1'b1, `CT_OFS_STATUS, 32'h2);
      chk_rd("capture signal off", `CT_OFS_STATUS, 32'h5, 32'h0);
      xfer(1'b1, `CT_OFS_PORT, 32'h1);
      repeat (4) @(posedge clk_in);
      check("rise on enable", 32'h1, {31'h0, capture_timer_request_flag_out});
      check("irq", 32'h1, {31'h0, irq_out});
      chk_rd("capture signal", `CT_OFS_STATUS, 32'h4, 32'h4);
      xfer(1'b1, `CT_OFS_STATUS, 32'h2);
      xfer(1'b1, `CT_OFS_MODE, 32'h02);
      xfer(1'b1, `CT_OFS_PORT, 32'h0);
      repeat (4) @(posedge clk_in);
      check("fall on disable", 32'h1, {31'h0, capture_timer_request_flag_out});
      // Pin low during switching gives no flag
      idle_level <= 1'b0;
      xfer(1'b1, `CT_OFS_MODE, 32'h12);
      xfer(1'b1, `CT_OFS_STATUS, 32'h2);
      xfer(1'b1, `CT_OFS_PORT, 32'h1);
      xfer(1'b1, `CT_OFS_PORT, 32'h0);
      repeat (4) @(posedge clk_in);
      check("no false edge", 32'h0, {31'h0, capture_timer_request_flag_out});
      // Pulse widths with clear on both edges
      xfer(1'b1, `CT_OFS_MODE, 32'h1e);
      xfer(1'b1, `CT_OFS_PORT, 32'h1);
      pulse(8'd40);
      repeat (98) @(posedge clk_in);
      pulse(8'd40);
      repeat (20) @(posedge clk_in);
      xfer(1'b0, `CT_OFS_FALL, 32'h0);
      check("high width", 32'h1, {31'h0, q >= 18 && q <= 22});
      xfer(1'b0, `CT_OFS_RISE, 32'h0);
      check("low width", 32'h1, {31'h0, q >= 28 && q <= 32});
      check("edge flag", 32'h1, {31'h0, capture_timer_request_flag_out});
      repeat (40) @(posedge clk_in);
      // Canceler switched with pin function cleared first
      xfer(1'b1, `CT_OFS_PORT, 32'h0);
      xfer(1'b1, `CT_OFS_MODE, 32'h02);
      xfer(1'b1, `CT_OFS_STATUS, 32'h2);
      xfer(1'b1, `CT_OFS_PORT, 32'h2);
      xfer(1'b1, `CT_OFS_PORT, 32'h3);
      repeat (16) @(posedge clk_in);
      check("fall before samples", 32'h1, {31'h0, capture_timer_request_flag_out});
      repeat (20) @(posedge clk_in);
      xfer(1'b1, `CT_OFS_MODE, 32'h12);
      xfer(1'b1, `CT_OFS_STATUS, 32'h2);
      pulse(8'd4);
      repeat (30) @(posedge clk_in);
      check("glitch dropped", 32'h0, {31'h0, capture_timer_request_flag_out});
      pulse(8'd40);
      repeat (60) @(posedge clk_in);
      check("pulse kept", 32'h1, {31'h0, capture_timer_request_flag_out});
      close_out();
   end
endmodule : test_capture_timer

bind capture_timer capture_timer_monitor #(.WATCH_DIV(WATCH_DIV)) mon (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .capture_input_port_pin_in(capture_input_port_pin_in), .power_mode_in(power_mode_in),
   .capture_timer_request_flag_out(capture_timer_request_flag_out), .irq_out(irq_out));
